/* vac_attribute.sv */
/*
 * Attribute stage of a VGA-compatible display path: palette, text and graphics
 * attribute handling, blink, panning, 8-bit pixel assembly and padding.
 * Assumes host I/O strobes are one-cycle pulses on the dot clock and that the
 * colour stream, text attributes and timing flags arrive aligned on that clock.
 */
`timescale 1ns/100ps
`default_nettype none
module vac_attribute
	import vac_pkg::*;
(
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_port_wr,
	input  wire logic         i_index_rd,
	input  wire logic         i_data_rd,
	input  wire logic         i_status_rd,
	input  wire logic [7:0]   i_wdata,
	input  wire logic [3:0]   i_plane_code,
	input  wire vac_text_type i_text,
	input  wire logic         i_border,
	input  wire logic         i_vertical_retrace_pulse,
	input  wire logic         i_line_compare,
	input  wire logic         i_vsync,
	input  wire logic         i_nine_dot,
	output logic      [7:0]   o_rdata,
	output logic      [7:0]   o_video,
	output logic              o_pixel_valid,
	output logic      [1:0]   o_diag_status,
	output logic              o_port_phase_flipflop
);
	vac_ctrl_type ctrl_reg;
	logic [5:0]   palette_entries_reg [16];
	logic [5:0]   index_reg;
	logic         phase_reg;
	logic [VAC_BLINK_BITS-1:0] blink_cnt_reg;
	logic         retrace_seen_reg;
	logic         pan_zero_reg;
	logic         pair_half_reg;
	logic [3:0]   low_nibble_reg;
	logic [7:0]   video_reg;
	logic         valid_reg;
	logic [1:0]   diag_reg;
	logic [7:0]   rdata_reg;

	// -----------------------------------------------------------------
	// Host port decode.
	// -----------------------------------------------------------------
	wire       index_write   = i_port_wr & ~phase_reg;
	wire       data_write    = i_port_wr & phase_reg;
	wire [4:0] reg_sel       = index_reg[4:0];
	wire       palette_owned = index_reg[VAC_IDX_OWNER];
	wire       palette_sel   = (reg_sel[4] == 1'b0);
	wire       pal_host_ok   = palette_sel & ~palette_owned; // RULE22

	wire mode_graphics = ctrl_reg.mode[VAC_MODE_GRAPHICS];
	wire mode_mono     = ctrl_reg.mode[VAC_MODE_MONO];
	wire mode_linegr   = ctrl_reg.mode[VAC_MODE_LINEGR];
	wire mode_blink    = ctrl_reg.mode[VAC_MODE_BLINK];
	wire mode_toppan   = ctrl_reg.mode[VAC_MODE_TOPPAN];
	wire mode_pix8     = ctrl_reg.mode[VAC_MODE_PIX8];
	wire mode_hisel    = ctrl_reg.mode[VAC_MODE_HISEL];

	// -----------------------------------------------------------------
	// Index register and port phase.
	// -----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			phase_reg <= 1'b0;
			index_reg <= 6'h00;
		end else begin
			if (i_status_rd) begin
				phase_reg <= 1'b0; // RULE21
			end else if (i_port_wr) begin
				phase_reg <= ~phase_reg; // RULE21
			end
			if (index_write) begin
				index_reg <= i_wdata[5:0];
			end
		end
	end

	// -----------------------------------------------------------------
	// Control registers.
	// -----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_reg <= {5{VAC_REG_RESET}}; // RULE20
		end else if (data_write) begin
			unique case (reg_sel) // RULE2
				VAC_IDX_MODE:   ctrl_reg.mode   <= i_wdata;
				VAC_IDX_BORDER: ctrl_reg.border <= i_wdata;
				VAC_IDX_PLANE:  ctrl_reg.plane  <= i_wdata;
				VAC_IDX_PAN:    ctrl_reg.pan    <= i_wdata;
				VAC_IDX_PAD:    ctrl_reg.pad    <= i_wdata;
				default:        ctrl_reg        <= ctrl_reg;
			endcase
		end
	end

	// Palette entries carry no reset; they are undefined until written.
	genvar p;
	generate
		for (p = 0; p < 16; p++) begin : g_pal
			always_ff @(posedge i_clk) begin
				if (data_write && pal_host_ok && reg_sel[3:0] == 4'(p)) begin
					palette_entries_reg[p] <= i_wdata[5:0]; // RULE2
				end
			end
		end
	endgenerate

	// -----------------------------------------------------------------
	// Read-back.
	// -----------------------------------------------------------------
	logic [7:0] data_view;
	always_comb begin
		unique case (reg_sel)
			VAC_IDX_MODE:   data_view = ctrl_reg.mode;
			VAC_IDX_BORDER: data_view = ctrl_reg.border;
			VAC_IDX_PLANE:  data_view = ctrl_reg.plane;
			VAC_IDX_PAN:    data_view = ctrl_reg.pan;
			VAC_IDX_PAD:    data_view = ctrl_reg.pad;
			default:        data_view = pal_host_ok ?
				{2'b00, palette_entries_reg[reg_sel[3:0]]} : 8'h00;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_reg <= 8'h00;
		end else if (i_index_rd) begin
			rdata_reg <= {2'b00, index_reg};
		end else if (i_data_rd) begin
			rdata_reg <= data_view;
		end
	end

	// -----------------------------------------------------------------
	// Blink divider and top panning.
	// -----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			blink_cnt_reg    <= '0;
			retrace_seen_reg <= 1'b0;
			pan_zero_reg     <= 1'b0;
		end else begin
			retrace_seen_reg <= i_vertical_retrace_pulse;
			if (i_vertical_retrace_pulse && !retrace_seen_reg) begin
				blink_cnt_reg <= blink_cnt_reg + 1'b1; // RULE7
			end
			if (i_vsync) begin
				pan_zero_reg <= 1'b0; // RULE10
			end else if (i_line_compare && mode_toppan) begin
				pan_zero_reg <= 1'b1; // RULE10
			end
		end
	end

	wire char_blink_off = blink_cnt_reg[VAC_CHAR_BLINK_B]; // RULE7
	wire curs_blink_off = blink_cnt_reg[VAC_CURS_BLINK_B]; // RULE9

	// -----------------------------------------------------------------
	// Text attribute resolution.
	// -----------------------------------------------------------------
	wire [7:0] attr     = i_text.attr;
	wire       linegr   = i_text.char_code >= VAC_LINEGR_LO &&
	                      i_text.char_code <= VAC_LINEGR_HI;
	wire       ninth_fg = mode_linegr & linegr & i_text.text_fg; // RULE5
	wire       dot_fg   = i_text.ninth_dot ? ninth_fg : i_text.text_fg;
	wire       blinking = mode_blink & attr[7] & char_blink_off; // RULE6
	wire       cursor_on = i_text.cursor & ~curs_blink_off; // RULE9
	wire [3:0] bg_color = mode_blink ? {1'b0, attr[6:4]} : attr[7:4]; // RULE6
	wire       mono_ul  = mode_mono & (attr[2:0] == 3'b001); // RULE4
	wire       mono_inv = mode_mono & (attr[6:4] == 3'b111) & (attr[2:0] == 3'b000);
	wire       show_fg  = (dot_fg & ~blinking) | cursor_on | (mono_ul & i_text.ninth_dot);
	wire [3:0] fg_color = mono_inv ? 4'h0 : attr[3:0];
	wire [3:0] bg_eff   = mono_inv ? 4'h7 : (mode_mono ? {bg_color[3], 3'b000} : bg_color);
	wire [3:0] text_code = show_fg ? fg_color : bg_eff; // RULE4

	// -----------------------------------------------------------------
	// Graphics blink, mode select, plane mask.
	// -----------------------------------------------------------------
	wire [3:0] gfx_code  = {i_plane_code[3] ^ (mode_blink & char_blink_off),
	                        i_plane_code[2:0]}; // RULE8
	wire [3:0] src_code  = mode_graphics ? gfx_code : text_code; // RULE3
	wire [3:0] mask_code = src_code & ctrl_reg.plane[3:0]; // RULE14

	// -----------------------------------------------------------------
	// Pan amount and shift.
	// -----------------------------------------------------------------
	wire [3:0] pan_prog  = (pan_zero_reg & mode_toppan) ? 4'h0 : ctrl_reg.pan[3:0]; // RULE10
	wire [3:0] pan_nine  = (pan_prog == VAC_PAN_NINE_ZERO) ? 4'h0 :
	                       4'({1'b0, pan_prog[2:0]} + 4'h1); // RULE16
	wire [3:0] pan_eight = {1'b0, pan_prog[2:0]}; // RULE17
	wire [3:0] pan_pix8  = {1'b0, pan_prog[3:1]}; // RULE18
	wire [3:0] pan_sel   = mode_pix8 ? {pan_pix8[2:0], 1'b0} :
	                       ((!mode_graphics && i_nine_dot) ? pan_nine : pan_eight);
	wire [3:0] shifted_code;

	vac_pan_shift u_pan (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_code (mask_code),
		.i_shift(pan_sel),
		.o_code (shifted_code)
	);

	// -----------------------------------------------------------------
	// Palette lookup and output formation.
	// -----------------------------------------------------------------
	wire [5:0] pal_out  = palette_entries_reg[shifted_code]; // RULE1
	wire [1:0] hi54     = mode_hisel ? ctrl_reg.pad[1:0] : pal_out[5:4]; // RULE12
	wire [7:0] pix4_val = {ctrl_reg.pad[3:2], hi54, pal_out[3:0]}; // RULE19
	wire [7:0] pix8_val = {low_nibble_reg, pal_out[3:0]}; // RULE11
	wire       border_now = i_border;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pair_half_reg  <= 1'b0;
			low_nibble_reg <= 4'h0;
			video_reg      <= 8'h00;
			valid_reg      <= 1'b0;
		end else if (border_now) begin
			pair_half_reg <= 1'b0;
			video_reg     <= ctrl_reg.border; // RULE13
			valid_reg     <= 1'b1;
		end else if (mode_pix8) begin
			pair_half_reg <= ~pair_half_reg; // RULE11
			if (!pair_half_reg) begin
				low_nibble_reg <= {hi54, pal_out[3:2]};
				valid_reg      <= 1'b0;
			end else begin
				video_reg <= pix8_val; // RULE11
				valid_reg <= 1'b1;
			end
		end else begin
			pair_half_reg <= 1'b0;
			video_reg     <= pix4_val;
			valid_reg     <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Diagnostic status.
	// -----------------------------------------------------------------
	wire [1:0] diag_sel = ctrl_reg.plane[5:4];
	wire [1:0] diag_pick = (diag_sel == 2'b00) ? {video_reg[2], video_reg[0]} :
	                       (diag_sel == 2'b01) ? {video_reg[5], video_reg[4]} :
	                       (diag_sel == 2'b10) ? {video_reg[3], video_reg[1]} :
	                                             {video_reg[7], video_reg[6]}; // RULE15

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			diag_reg <= 2'b00;
		end else begin
			diag_reg <= diag_pick; // RULE15
		end
	end

	assign o_rdata               = rdata_reg;
	assign o_video               = video_reg;
	assign o_pixel_valid         = valid_reg;
	assign o_diag_status         = diag_reg;
	assign o_port_phase_flipflop = phase_reg;
endmodule : vac_attribute
`default_nettype wire

/* vac_pkg.sv */
/*
 * Package for the video attribute stage: register indices, field positions,
 * reset values, blink divider figures and the carrier structs.
 * Assumes a single dot clock domain and an 8-bit host I/O port pair.
 */
// Functional notes
// RULE1: Sixteen six-bit palette entries, colour code selects, bits drive the six palette outputs.
// RULE2: Data port write updates the attribute register chosen by the current index.
// RULE3: Mode bit 0 clear selects text attributes, set selects graphics colour handling.
// RULE4: Mode bit 1 set gives monochrome text attributes, clear gives colour text.
// RULE5: Line graphics on copies dot eight into dot nine for codes c0 to df.
// RULE6: Mode bit 3 turns attribute top bit from background intensity into blink.
// RULE7: Character blink divides retrace pulses by 32, sixteen on and sixteen off.
// RULE8: Graphics blink inverts colour bit 3 on alternate sixteen retrace phases.
// RULE9: Text cursor blinks eight retraces on and eight off, independent of characters.
// RULE10: Top panning forces pan to zero from line compare until vertical sync.
// RULE11: Eight-bit mode pairs two nibbles into one pixel at half dot rate.
// RULE12: High bits select replaces video bits 5 and 4 with padding bits 1 and 0; in eight-bit mode the code puts them on video bits 7 and 6.
// RULE13: Border region shows the eight-bit border colour register value.
// RULE14: Cleared plane enable bit forces that colour plane bit to zero before lookup.
// RULE15: Diagnostic select routes video pairs 2/0, 5/4, 3/1, 7/6 to status bits.
// RULE16: Nine-dot text shifts count plus one for 0 to 7, zero for 8.
// RULE17: Eight-dot text and ordinary graphics shift exactly the pan count.
// RULE18: Eight-bit mode shifts half the count; software keeps count bit 0 clear.
// RULE19: Outside eight-bit mode padding bits 3 and 2 drive video bits 7 and 6.
// RULE20: Reset clears mode, border, plane, pan and padding registers; palette undefined.
// RULE21: Status read presets port phase to index; writes toggle it; reads never do.
// RULE22: Index bits 4-0 select register; bit 5 gives palette to display, blocks host.
// RULE23: All pipeline state runs on the dot clock and clears on reset.
package vac_pkg;
	localparam logic [4:0] VAC_IDX_MODE      = 5'h10;
	localparam logic [4:0] VAC_IDX_BORDER    = 5'h11;
	localparam logic [4:0] VAC_IDX_PLANE     = 5'h12;
	localparam logic [4:0] VAC_IDX_PAN       = 5'h13;
	localparam logic [4:0] VAC_IDX_PAD       = 5'h14;
	localparam int         VAC_MODE_GRAPHICS = 0;
	localparam int         VAC_MODE_MONO     = 1;
	localparam int         VAC_MODE_LINEGR   = 2;
	localparam int         VAC_MODE_BLINK    = 3;
	localparam int         VAC_MODE_TOPPAN   = 5;
	localparam int         VAC_MODE_PIX8     = 6;
	localparam int         VAC_MODE_HISEL    = 7;
	localparam int         VAC_IDX_OWNER     = 5;
	localparam logic [7:0] VAC_REG_RESET     = 8'h00;
	localparam logic [7:0] VAC_LINEGR_LO     = 8'hc0;
	localparam logic [7:0] VAC_LINEGR_HI     = 8'hdf;
	localparam logic [3:0] VAC_PAN_NINE_ZERO = 4'h8;
	localparam int         VAC_BLINK_BITS    = 5;
	localparam int         VAC_CHAR_BLINK_B  = 4;
	localparam int         VAC_CURS_BLINK_B  = 3;
	localparam int         VAC_SHIFT_DEPTH   = 16;

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] border;
		logic [7:0] plane;
		logic [7:0] pan;
		logic [7:0] pad;
	} vac_ctrl_type;

	typedef struct packed {
		logic       text_fg;
		logic       cursor;
		logic       ninth_dot;
		logic [7:0] char_code;
		logic [7:0] attr;
	} vac_text_type;
endpackage : vac_pkg

/* vac_pan_shift.sv */
/*
 * Horizontal pan delay line: holds the last sixteen 4-bit colour codes and
 * returns the one selected by the shift amount.
 * Assumes the caller computes the shift in dot-clock positions.
 */
`timescale 1ns/100ps
`default_nettype none
module vac_pan_shift
	import vac_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic [3:0] i_code,
	input  wire logic [3:0] i_shift,
	output logic      [3:0] o_code
);
	logic [3:0] tap_reg [VAC_SHIFT_DEPTH];

	// -----------------------------------------------------------------
	// Delay taps.
	// -----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < VAC_SHIFT_DEPTH; g++) begin : g_tap
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					tap_reg[g] <= 4'h0;
				end else begin
					tap_reg[g] <= (g == 0) ? i_code : tap_reg[(g == 0) ? 0 : g - 1]; // RULE23
				end
			end
		end
	endgenerate

	// A larger shift reads a younger tap, so the picture moves left.
	assign o_code = tap_reg[4'(VAC_SHIFT_DEPTH - 1) - i_shift];
endmodule : vac_pan_shift
`default_nettype wire

/* vac_attribute_monitor.sv */
/*
 * Port checker for the attribute stage: host port phase, read data and pixel output relations.
 * Assumes one dot clock and an active-high asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module vac_attribute_monitor
	import vac_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       i_port_wr,
	input wire logic       i_index_rd,
	input wire logic       i_data_rd,
	input wire logic       i_status_rd,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] o_video,
	input wire logic       o_pixel_valid,
	input wire logic [1:0] o_diag_status,
	input wire logic       o_port_phase_flipflop
);
	logic [7:0] wd1_reg;
	logic [7:0] wd2_reg;
	logic [7:0] vprev_reg;
	logic [1:0] live_reg;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wd1_reg   <= '0;
			wd2_reg   <= '0;
			vprev_reg <= '0;
			live_reg  <= '0;
		end else begin
			wd1_reg   <= i_wdata;
			wd2_reg   <= wd1_reg;
			vprev_reg <= o_video;
			if (live_reg != 2'h3)
				live_reg <= live_reg + 2'h1;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_phase_write_toggle: assert property (
		i_port_wr && !i_status_rd |=> o_port_phase_flipflop != $past(o_port_phase_flipflop))
		else $error("port phase did not toggle on a write");
	a_phase_status_preset: assert property (
		i_status_rd |=> !o_port_phase_flipflop) else $error("status read did not preset phase");
	a_phase_read_hold: assert property (
		(i_index_rd || i_data_rd) && !i_port_wr && !i_status_rd |=> $stable(o_port_phase_flipflop))
		else $error("port phase changed on a read");
	a_rdata_stands: assert property (
		!i_index_rd && !i_data_rd |=> $stable(o_rdata)) else $error("read data changed without read");
	a_index_read_back: assert property (
		i_port_wr && !i_status_rd && !o_port_phase_flipflop ##1 i_index_rd && !i_port_wr
		&& !i_status_rd |=> o_rdata[5:0] == wd2_reg[5:0]) else $error("index read back wrong");
	a_pixel_gap_single: assert property (
		live_reg == 2'h3 && !o_pixel_valid |=> o_pixel_valid) else $error("pixel valid low twice");
	a_pixel_pair_hold: assert property (
		live_reg == 2'h3 && !o_pixel_valid |-> $stable(o_video)) else $error("video moved while not valid");
	a_diag_pair_route: assert property (
		o_diag_status == {vprev_reg[2], vprev_reg[0]} || o_diag_status == vprev_reg[5:4]
		|| o_diag_status == {vprev_reg[3], vprev_reg[1]} || o_diag_status == vprev_reg[7:6])
		else $error("diagnostic pair not taken from video");
endmodule : vac_attribute_monitor
bind vac_attribute vac_attribute_monitor mon_u (.i_clk(i_clk), .i_rst(i_rst), .i_port_wr(i_port_wr),
	.i_index_rd(i_index_rd), .i_data_rd(i_data_rd), .i_status_rd(i_status_rd), .i_wdata(i_wdata),
	.o_rdata(o_rdata), .o_video(o_video), .o_pixel_valid(o_pixel_valid),
	.o_diag_status(o_diag_status), .o_port_phase_flipflop(o_port_phase_flipflop));
`default_nettype wire

/* vac_host_model.sv */
/*
 * Host processor model: drives the shared index/data port and status read strobes.
 * Assumes strobes are sampled on the rising dot clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module vac_host_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	output logic            o_port_wr,
	output logic            o_index_rd,
	output logic            o_data_rd,
	output logic            o_status_rd,
	output logic      [7:0] o_wdata
);
	initial begin
		o_port_wr = 0;
		o_index_rd = 0;
		o_data_rd = 0;
		o_status_rd = 0;
		o_wdata = '0;
	end
	task op(input logic w, input logic ir, input logic dr, input logic sr, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_port_wr = w;
		o_index_rd = ir;
		o_data_rd = dr;
		o_status_rd = sr;
		o_wdata = d;
	endtask : op
	task reg_wr(input logic [7:0] idx, input logic [7:0] d);
		op(0, 0, 0, 1, 8'h00);
		op(1, 0, 0, 0, idx);
		op(1, 0, 0, 0, d);
		op(0, 0, 0, 0, 8'h00);
	endtask : reg_wr
	task reg_rd(input logic [7:0] idx, output logic [7:0] v);
		op(0, 0, 0, 1, 8'h00);
		op(1, 0, 0, 0, idx);
		op(0, 1, 0, 0, 8'h00);
		op(0, 0, 1, 0, 8'h00);
		op(0, 0, 0, 0, 8'h00);
		v = i_rdata;
	endtask : reg_rd
endmodule : vac_host_model
`default_nettype wire

/* vac_attribute_controller_tb.sv */
/*
 * Self-checking bench for the attribute stage: register access, palette, border, masking,
 * padding, diagnostics, blink and 8-bit pixels. Assumes vac_pkg and the host model.
 */
`timescale 1ns/100ps
`default_nettype none
module vac_attribute_controller_tb;
	import vac_pkg::*;
	logic clk, rst, pwr, ird, drd, srd, border, vrp;
	logic [7:0] wd, rdata, video, rd, mode_v, plane_v, pad_v, v0, v16, e;
	logic [3:0] code;
	logic [5:0] p;
	logic [1:0] diag;
	logic valid, phase;
	logic lc, vs, nd;
	vac_text_type txt;
	int errors, tests_run, cycles, n;
	logic [7:0] wv [5] = '{8'h01, 8'h5a, 8'h3c, 8'h06, 8'h0d};
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	vac_host_model host_u (.i_clk(clk), .i_rdata(rdata), .o_port_wr(pwr), .o_index_rd(ird),
		.o_data_rd(drd), .o_status_rd(srd), .o_wdata(wd));
	vac_attribute dut_u (.i_clk(clk), .i_rst(rst), .i_port_wr(pwr), .i_index_rd(ird),
		.i_data_rd(drd), .i_status_rd(srd), .i_wdata(wd), .i_plane_code(code), .i_text(txt),
		.i_border(border), .i_vertical_retrace_pulse(vrp), .i_line_compare(lc),
		.i_vsync(vs), .i_nine_dot(nd), .o_rdata(rdata), .o_video(video),
		.o_pixel_valid(valid), .o_diag_status(diag), .o_port_phase_flipflop(phase));
	function automatic logic [5:0] pv(input logic [3:0] i);
		return {i[1:0], ~i};
	endfunction : pv
	function automatic logic [7:0] ev(input logic [3:0] c);
		logic [5:0] q;
		q = pv(c & plane_v[3:0]);
		if (mode_v[7])
			q[5:4] = pad_v[1:0];
		return {pad_v[3:2], q};
	endfunction : ev
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task settle(input logic [3:0] c);
		@(posedge clk);
		#1 code = c;
		txt.attr[3:0] = c;
		repeat (40) @(posedge clk);
		#1;
	endtask : settle
	task retr(input int k);
		repeat (k) begin
			@(posedge clk);
			#1 vrp = 1;
			@(posedge clk);
			#1 vrp = 0;
		end
	endtask : retr
	task strobe(input logic l, input logic v);
		@(posedge clk);
		#1 lc = l;
		vs = v;
		@(posedge clk);
		#1 lc = 0;
		vs = 0;
	endtask : strobe
	task lat(input logic [3:0] c, input int k);
		n = 0;
		@(posedge clk);
		#1 code = c;
		txt.attr[3:0] = c;
		while (video !== ev(c) && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		check("pan_latency", 8'(n), 8'(k));
	endtask : lat
	task setv(input logic [7:0] m, input logic [7:0] pl, input logic [7:0] pd);
		host_u.reg_wr(8'h30, m);
		host_u.reg_wr(8'h32, pl);
		host_u.reg_wr(8'h34, pd);
		mode_v = m;
		plane_v = pl;
		pad_v = pd;
	endtask : setv
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end
	initial begin
		rst = 1;
		border = 1;
		vrp = 0;
		code = '0;
		txt = '0;
		lc = 0;
		vs = 0;
		nd = 0;
		repeat (4) @(posedge clk);
		#1 rst = 0;
		for (int k = 0; k < 5; k++) begin
			host_u.reg_rd(8'(8'h30 + k), rd);
			check("reset_value", rd, VAC_REG_RESET);
		end
		check("phase_after_read", {7'h0, phase}, 8'h01);
		for (int k = 0; k < 5; k++) begin
			host_u.reg_wr(8'(8'h30 + k), wv[k]);
			host_u.reg_rd(8'(8'h30 + k), rd);
			check("reg_readback", rd, wv[k]);
		end
		host_u.reg_wr(8'h35, 8'hff);
		check("phase_after_write", {7'h0, phase}, 8'h00);
		host_u.reg_rd(8'h35, rd);
		check("reserved_index", rd, 8'h00);
		for (int i = 0; i < 16; i++)
			host_u.reg_wr(8'(i), {2'b00, pv(4'(i))});
		host_u.reg_rd(8'h03, rd);
		check("palette_read", rd, {2'b00, pv(3)});
		host_u.reg_rd(8'h23, rd);
		check("palette_blocked", rd, 8'h00);
		settle(4'h0);
		check("border_colour", video, 8'h5a);
		border = 0;
		setv(8'h01, 8'h0f, 8'h0c);
		for (int c = 0; c < 16; c++) begin
			settle(4'(c));
			check("palette_video", video, ev(4'(c)));
		end
		setv(8'h81, 8'h05, 8'h0e);
		settle(4'hf);
		check("mask_pad_video", video, ev(4'hf));
		for (int s = 0; s < 4; s++) begin
			setv(8'h01, {2'b00, 2'(s), 4'hf}, 8'h0c);
			settle(4'h9);
			e = ev(4'h9);
			case (s)
				0: check("diag_pair", {6'h0, diag}, {6'h0, e[2], e[0]});
				1: check("diag_pair", {6'h0, diag}, {6'h0, e[5:4]});
				2: check("diag_pair", {6'h0, diag}, {6'h0, e[3], e[1]});
				default: check("diag_pair", {6'h0, diag}, {6'h0, e[7:6]});
			endcase
		end
		setv(8'h09, 8'h0f, 8'h00);
		settle(4'h3);
		v0 = video;
		check("blink_phase0", v0, ev(4'h3));
		retr(16);
		settle(4'h3);
		v16 = video;
		check("blink_toggle", v0 ^ v16, {2'b00, pv(3) ^ pv(11)});
		retr(16);
		settle(4'h3);
		check("blink_period", video, v0);
		setv(8'h01, 8'h0f, 8'h00);
		retr(16);
		settle(4'h3);
		check("blink_disabled", video, ev(4'h3));
		setv(8'h41, 8'h0f, 8'h00);
		settle(4'h5);
		p = pv(5);
		check("pixel8_video", video, {p[5:2], p[3:0]});
		n = 0;
		repeat (8) begin
			@(posedge clk);
			#1 n += valid;
		end
		check("pixel8_rate", 8'(n), 8'h04);
		txt.text_fg = 1;
		host_u.reg_wr(8'h33, 8'h03);
		setv(8'h21, 8'h0f, 8'h00);
		strobe(1, 0);
		settle(4'h1);
		lat(4'h2, VAC_SHIFT_DEPTH + 1);
		setv(8'h01, 8'h0f, 8'h00);
		settle(4'h1);
		lat(4'h2, VAC_SHIFT_DEPTH - 2);
		setv(8'h21, 8'h0f, 8'h00);
		strobe(0, 1);
		settle(4'h1);
		lat(4'h2, VAC_SHIFT_DEPTH - 2);
		setv(8'h00, 8'h0f, 8'h00);
		nd = 1;
		settle(4'h1);
		lat(4'h2, VAC_SHIFT_DEPTH - 3);
		host_u.reg_wr(8'h33, 8'h08);
		settle(4'h1);
		lat(4'h2, VAC_SHIFT_DEPTH + 1);
		nd = 0;
		host_u.reg_wr(8'h33, 8'h03);
		settle(4'h1);
		lat(4'h2, VAC_SHIFT_DEPTH - 2);
		txt.attr[7:4] = 4'ha;
		txt.text_fg = 0;
		settle(4'h6);
		check("text_background", video, ev(4'ha));
		setv(8'h08, 8'h0f, 8'h00);
		settle(4'h6);
		check("blink_background", video, ev(4'h2));
		txt.text_fg = 1;
		settle(4'h6);
		check("char_blink_off", video, ev(4'h2));
		setv(8'h00, 8'h0f, 8'h00);
		txt.text_fg = 0;
		txt.cursor = 1;
		settle(4'h6);
		check("cursor_on", video, ev(4'h6));
		retr(8);
		settle(4'h6);
		check("cursor_off", video, ev(4'ha));
		txt.cursor = 0;
		setv(8'h04, 8'h0f, 8'h00);
		txt.text_fg = 1;
		txt.ninth_dot = 1;
		txt.char_code = 8'hc4;
		settle(4'h6);
		check("line_graphics", video, ev(4'h6));
		txt.char_code = 8'h41;
		settle(4'h6);
		check("ninth_background", video, ev(4'ha));
		tally_and_finish();
	end
endmodule : vac_attribute_controller_tb
`default_nettype wire
